// ===== rtl/pcr_ctrl_bank.sv
// Basic control register, latching status word and loopback path of the PHY.
// Assumes single-cycle register requests already decoded from management frames.
`timescale 1ns/1ps
module pcr_ctrl_bank (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_mgmt_req,
  input wire logic i_mgmt_we,
  input wire logic [4:0] i_mgmt_addr,
  input wire logic [15:0] i_mgmt_wdata,
  output logic o_mgmt_ack,
  output logic [15:0] o_mgmt_rdata,
  input wire logic [4:0] i_phy_addr,
  input wire logic i_sw_mode,
  input wire logic i_hw_speed_100,
  input wire logic i_an_speed_100,
  input wire logic i_an_started,
  input wire logic [pcr_pkg::LH_COUNT-1:0] i_lh_event,
  input wire logic i_ll_level,
  input wire logic [pcr_pkg::MAX_WIDTH-1:0] i_sm_state,
  input wire logic [3:0] i_mac_txd,
  input wire logic i_mac_tx_en,
  input wire logic [3:0] i_line_rxd,
  input wire logic i_line_rx_dv,
  input wire logic i_line_col,
  output logic [3:0] o_mac_rxd,
  output logic o_mac_rx_dv,
  output logic o_mac_col,
  output logic o_mac_oe,
  output logic o_tp_tx_en,
  output logic o_tp_rx_en,
  output logic o_col_det_en,
  output logic o_speed_100,
  output logic o_full_duplex,
  output logic o_an_enable,
  output logic o_an_restart,
  output logic o_low_power,
  output logic o_sm_idle
);
  logic rst_busy;
  logic [pcr_pkg::RST_CNT_WIDTH-1:0] rst_cnt;
  logic strap_done;
  logic iso_default;
  logic loopback;
  logic speed_100;
  logic an_enable;
  logic low_power;
  logic isolate;
  logic an_restart;
  logic full_duplex;
  logic col_test;
  logic wr_ctrl;
  logic rd_status;
  logic load_def;
  logic latch_init;
  logic [15:0] ctrl_word;
  logic [15:0] status_word;
  logic ll_bit;
  logic [pcr_pkg::LH_COUNT-1:0] lh_bits;
  logic [pcr_pkg::MAX_WIDTH-1:0] max_group;

  // Writes and status reads take no effect while the software reset runs; every request is still answered.
  assign wr_ctrl = i_mgmt_req && i_mgmt_we && !rst_busy
    && (i_mgmt_addr == pcr_pkg::ADDR_BASIC_CONTROL);
  assign rd_status = i_mgmt_req && !i_mgmt_we && !rst_busy
    && (i_mgmt_addr == pcr_pkg::ADDR_LATCH_STATUS);
  assign load_def = rst_busy && (rst_cnt == '0);
  assign latch_init = load_def
    || (wr_ctrl && i_mgmt_wdata[pcr_pkg::BIT_LOW_POWER] && !low_power);

  // The strap is caught on the first edge after reset release.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      strap_done <= 1'b0;
      iso_default <= pcr_pkg::DEF_ISOLATE_PRE_STRAP;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      iso_default <= (i_phy_addr == pcr_pkg::ISOLATE_PHY_ADDR);
    end
  end

  // Software reset sequencer; bit 15 reads one until the count expires.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_busy <= 1'b0;
      rst_cnt <= '0;
    end else if (wr_ctrl && i_mgmt_wdata[pcr_pkg::BIT_SW_RESET]) begin
      rst_busy <= 1'b1;
      rst_cnt <= pcr_pkg::RST_CNT_WIDTH'(pcr_pkg::SW_RESET_CYCLES);
    end else if (rst_busy) begin
      if (rst_cnt == '0) begin
        rst_busy <= 1'b0;
      end else begin
        rst_cnt <= rst_cnt - 1'b1;
      end
    end
  end

  // Control fields; defaults are reloaded as the software reset finishes.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      loopback <= 1'b0;
      speed_100 <= pcr_pkg::DEF_SPEED_100;
      an_enable <= pcr_pkg::DEF_AN_ENABLE;
      low_power <= 1'b0;
      isolate <= pcr_pkg::DEF_ISOLATE_PRE_STRAP;
      full_duplex <= 1'b0;
      col_test <= 1'b0;
    end else if (!strap_done || load_def) begin
      loopback <= 1'b0;
      speed_100 <= pcr_pkg::DEF_SPEED_100;
      an_enable <= pcr_pkg::DEF_AN_ENABLE;
      low_power <= 1'b0;
      isolate <= strap_done ? iso_default : (i_phy_addr == pcr_pkg::ISOLATE_PHY_ADDR);
      full_duplex <= 1'b0;
      col_test <= 1'b0;
    end else if (wr_ctrl) begin
      loopback <= i_mgmt_wdata[pcr_pkg::BIT_LOOPBACK];
      speed_100 <= i_mgmt_wdata[pcr_pkg::BIT_SPEED_100];
      an_enable <= i_mgmt_wdata[pcr_pkg::BIT_AN_ENABLE];
      low_power <= i_mgmt_wdata[pcr_pkg::BIT_LOW_POWER];
      isolate <= i_mgmt_wdata[pcr_pkg::BIT_ISOLATE];
      full_duplex <= i_mgmt_wdata[pcr_pkg::BIT_FULL_DUPLEX];
      col_test <= i_mgmt_wdata[pcr_pkg::BIT_COL_TEST];
    end
  end

  // Restart bit is taken only with negotiation enabled and drops once negotiation starts.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      an_restart <= 1'b0;
    end else if (load_def) begin
      an_restart <= 1'b0;
    end else if (wr_ctrl && i_mgmt_wdata[pcr_pkg::BIT_AN_RESTART]
                 && i_mgmt_wdata[pcr_pkg::BIT_AN_ENABLE]) begin
      an_restart <= 1'b1;
    end else if (i_an_started) begin
      an_restart <= 1'b0;
    end
  end

  for (genvar g = 0; g < pcr_pkg::LH_COUNT; g++) begin : g_lh
    pcr_latch_bit #(
      .ACTIVE(1'b1)
    ) u_lh (
      .i_core_clk(i_core_clk),
      .i_arst_n(i_arst_n),
      .i_init(latch_init),
      .i_reload(rd_status),
      .i_level(i_lh_event[g]),
      .o_bit(lh_bits[g])
    );
  end

  pcr_latch_bit #(
    .ACTIVE(1'b0)
  ) u_ll (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_init(latch_init),
    .i_reload(rd_status),
    .i_level(i_ll_level),
    .o_bit(ll_bit)
  );

  // Maximum tracker compares the whole group as one unsigned number.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      max_group <= '0;
    end else if (load_def) begin
      max_group <= '0;
    end else if (rd_status) begin
      max_group <= i_sm_state;
    end else if (i_sm_state > max_group) begin
      max_group <= i_sm_state;
    end
  end

  always_comb begin
    ctrl_word = '0;
    ctrl_word[pcr_pkg::BIT_SW_RESET] = rst_busy;
    ctrl_word[pcr_pkg::BIT_LOOPBACK] = loopback;
    ctrl_word[pcr_pkg::BIT_SPEED_100] = speed_100;
    ctrl_word[pcr_pkg::BIT_AN_ENABLE] = an_enable;
    ctrl_word[pcr_pkg::BIT_LOW_POWER] = low_power;
    ctrl_word[pcr_pkg::BIT_ISOLATE] = isolate;
    ctrl_word[pcr_pkg::BIT_AN_RESTART] = an_restart;
    ctrl_word[pcr_pkg::BIT_FULL_DUPLEX] = full_duplex;
    ctrl_word[pcr_pkg::BIT_COL_TEST] = col_test;
    status_word = '0;
    status_word[pcr_pkg::ST_LL_BIT] = ll_bit;
    status_word[pcr_pkg::ST_LH_LO +: pcr_pkg::LH_COUNT] = lh_bits;
    status_word[pcr_pkg::ST_MAX_LO +: pcr_pkg::MAX_WIDTH] = max_group;
  end

  // Read data is captured on the same edge that reloads the latching bits.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_mgmt_ack <= 1'b0;
      o_mgmt_rdata <= '0;
    end else begin
      o_mgmt_ack <= i_mgmt_req;
      if (i_mgmt_req && !i_mgmt_we) begin
        if (i_mgmt_addr == pcr_pkg::ADDR_BASIC_CONTROL) begin
          o_mgmt_rdata <= ctrl_word;
        end else if (rd_status) begin
          o_mgmt_rdata <= status_word;
        end else begin
          o_mgmt_rdata <= '0;
        end
      end
    end
  end

  // Loopback returns transmit data one clock later, far inside 512 bit times.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_mac_rxd <= '0;
      o_mac_rx_dv <= 1'b0;
      o_mac_col <= 1'b0;
    end else if (low_power || rst_busy) begin
      o_mac_rxd <= '0;
      o_mac_rx_dv <= 1'b0;
      o_mac_col <= 1'b0;
    end else if (loopback) begin
      o_mac_rxd <= i_mac_txd;
      o_mac_rx_dv <= i_mac_tx_en;
      o_mac_col <= col_test && i_mac_tx_en;
    end else begin
      o_mac_rxd <= i_line_rxd;
      o_mac_rx_dv <= i_line_rx_dv;
      o_mac_col <= col_test ? i_mac_tx_en : i_line_col;
    end
  end

  // Mode outputs registered; speed follows bit 13 only in software mode without negotiation.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_speed_100 <= 1'b0;
      o_tp_tx_en <= 1'b0;
      o_tp_rx_en <= 1'b0;
      o_col_det_en <= 1'b0;
      o_mac_oe <= 1'b0;
    end else begin
      if (!i_sw_mode) begin
        o_speed_100 <= i_hw_speed_100;
      end else if (an_enable) begin
        o_speed_100 <= i_an_speed_100;
      end else begin
        o_speed_100 <= speed_100;
      end
      o_tp_tx_en <= !loopback && !low_power;
      o_tp_rx_en <= !loopback && !low_power;
      o_col_det_en <= (!loopback || col_test) && !low_power;
      o_mac_oe <= !isolate && strap_done;
    end
  end

  assign o_full_duplex = full_duplex && !loopback;
  assign o_an_enable = an_enable;
  assign o_an_restart = an_restart;
  assign o_low_power = low_power;
  assign o_sm_idle = rst_busy;
endmodule : pcr_ctrl_bank

// ===== rtl/pcr_pkg.sv
// Constants for the management register bank of the Ethernet PHY control block.
// Assumes one 250 MHz core clock and a decoded register access port from the serial manager.
package pcr_pkg;
  localparam logic [4:0] ADDR_BASIC_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_LATCH_STATUS = 5'h01;
  localparam int BIT_SW_RESET = 15;
  localparam int BIT_LOOPBACK = 14;
  localparam int BIT_SPEED_100 = 13;
  localparam int BIT_AN_ENABLE = 12;
  localparam int BIT_LOW_POWER = 11;
  localparam int BIT_ISOLATE = 10;
  localparam int BIT_AN_RESTART = 9;
  localparam int BIT_FULL_DUPLEX = 8;
  localparam int BIT_COL_TEST = 7;
  localparam logic DEF_SPEED_100 = 1'b1;
  localparam logic DEF_AN_ENABLE = 1'b1;
  localparam logic DEF_ISOLATE_PRE_STRAP = 1'b1;
  localparam logic [4:0] ISOLATE_PHY_ADDR = 5'h00;
  localparam int ST_LL_BIT = 0;
  localparam int ST_LH_LO = 1;
  localparam int LH_COUNT = 2;
  localparam int ST_MAX_LO = 3;
  localparam int MAX_WIDTH = 3;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SW_RESET_TIME_NS = 1000;
  localparam int SW_RESET_CYCLES = (SW_RESET_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int RST_CNT_WIDTH = 9;
endpackage : pcr_pkg

// ===== rtl/pcr_latch_bit.sv
// One latching status bit, latch-high or latch-low by parameter.
// Assumes the monitored level is synchronous to the core clock.
`timescale 1ns/1ps
module pcr_latch_bit #(
  parameter logic ACTIVE = 1'b1
) (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_init,
  input wire logic i_reload,
  input wire logic i_level,
  output logic o_bit
);
  // An active level always wins, so an event meeting a read or an init is never lost.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_bit <= ~ACTIVE;
    end else if (i_level == ACTIVE) begin
      o_bit <= ACTIVE;
    end else if (i_init) begin
      o_bit <= ~ACTIVE;
    end else if (i_reload) begin
      o_bit <= i_level;
    end
  end
endmodule : pcr_latch_bit

// ===== tb/pcr_ctrl_bank_props.sv
// Checker for the control bank ports: answer timing, reset busy and control bits.
// Assumes one core clock and the asynchronous active-low reset of the bank.
`timescale 1ns/1ps
module pcr_ctrl_bank_props (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_mgmt_req,
  input wire logic i_mgmt_we,
  input wire logic [4:0] i_mgmt_addr,
  input wire logic [15:0] i_mgmt_wdata,
  input wire logic o_mgmt_ack,
  input wire logic [15:0] o_mgmt_rdata,
  input wire logic i_an_started,
  input wire logic o_mac_rx_dv,
  input wire logic [3:0] o_mac_rxd,
  input wire logic o_an_enable,
  input wire logic o_an_restart,
  input wire logic o_low_power,
  input wire logic o_sm_idle
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  wire logic rd0 = i_mgmt_req && !i_mgmt_we && i_mgmt_addr == 5'h00;
  wire logic rd1 = i_mgmt_req && !i_mgmt_we && i_mgmt_addr == 5'h01;
  wire logic wr0 = i_mgmt_req && i_mgmt_we && i_mgmt_addr == 5'h00;
  property p_ack; i_mgmt_req |=> o_mgmt_ack; endproperty
  a_ack: assert property (p_ack) else $error("no answer after request");
  property p_no_ack; !i_mgmt_req |=> !o_mgmt_ack; endproperty
  a_no_ack: assert property (p_no_ack) else $error("answer without request");
  property p_busy; wr0 && i_mgmt_wdata[15] && !o_sm_idle |-> ##[1:2] o_sm_idle; endproperty
  a_busy: assert property (p_busy) else $error("software reset did not start");
  property p_busy_len; $rose(o_sm_idle) |-> o_sm_idle [*8]; endproperty
  a_busy_len: assert property (p_busy_len) else $error("software reset too short");
  property p_rst_rd; (rd0 && o_sm_idle ##1 o_sm_idle) |-> o_mgmt_rdata[15]; endproperty
  a_rst_rd: assert property (p_rst_rd) else $error("busy bit not shown");
  property p_rst_st; (rd1 && o_sm_idle ##1 o_sm_idle) |-> o_mgmt_rdata == 16'h0000; endproperty
  a_rst_st: assert property (p_rst_st) else $error("status read not ignored");
  property p_rsvd; rd0 |=> o_mgmt_rdata[6:0] == 7'h00; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved control bits not zero");
  property p_an_rose; $rose(o_an_restart) |-> o_an_enable; endproperty
  a_an_rose: assert property (p_an_rose) else $error("restart without negotiation");
  property p_an_clr; o_an_restart && i_an_started && !i_mgmt_req |=> !o_an_restart; endproperty
  a_an_clr: assert property (p_an_clr) else $error("restart bit not cleared");
  property p_lp; o_low_power && $past(o_low_power) |-> !o_mac_rx_dv && o_mac_rxd == 4'h0;
  endproperty
  a_lp: assert property (p_lp) else $error("MAC outputs active in low power");
  c_busy: cover property ($rose(o_sm_idle));
  c_rst_rd: cover property (rd0 && o_sm_idle);
  c_an: cover property ($rose(o_an_restart));
endmodule : pcr_ctrl_bank_props
bind pcr_ctrl_bank pcr_ctrl_bank_props u_pcr_ctrl_bank_props (.i_core_clk, .i_arst_n,
  .i_mgmt_req, .i_mgmt_we, .i_mgmt_addr, .i_mgmt_wdata, .o_mgmt_ack, .o_mgmt_rdata,
  .i_an_started, .o_mac_rx_dv, .o_mac_rxd, .o_an_enable, .o_an_restart, .o_low_power,
  .o_sm_idle);

// ===== tb/pcr_sta_model.sv
// Station manager model: issues one-cycle register requests and takes the answers.
// Assumes the bank answers exactly one cycle after it takes a request.
`timescale 1ns/1ps
module pcr_sta_model (
  input wire logic i_core_clk,
  input wire logic i_mgmt_ack,
  input wire logic [15:0] i_mgmt_rdata,
  output logic o_mgmt_req,
  output logic o_mgmt_we,
  output logic [4:0] o_mgmt_addr,
  output logic [15:0] o_mgmt_wdata
);
  initial begin
    o_mgmt_req = 1'b0;
    o_mgmt_we = 1'b0;
    o_mgmt_addr = 5'h1f;
    o_mgmt_wdata = 16'h0000;
  end
  task automatic xfer(input logic we, input logic [4:0] a, input logic [15:0] d,
                      output logic [15:0] rdata, output logic ok);
    @(posedge i_core_clk);
    #1;
    o_mgmt_req = 1'b1;
    o_mgmt_we = we;
    o_mgmt_addr = a;
    o_mgmt_wdata = (a == 5'h00) ? (d & 16'hff80) : d;
    @(posedge i_core_clk);
    #1;
    // Released lines carry the inverse so stale values cannot pass.
    o_mgmt_req = 1'b0;
    o_mgmt_we = ~we;
    o_mgmt_addr = ~a;
    o_mgmt_wdata = ~o_mgmt_wdata;
    ok = (i_mgmt_ack === 1'b1);
    rdata = i_mgmt_rdata;
  endtask : xfer
endmodule : pcr_sta_model

// ===== tb/test_pcr_ctrl_bank.sv
// Self-checking bench for the control bank: defaults, latching bits, loopback, resets.
// Assumes the station manager model makes every register request.
`timescale 1ns/1ps
module test_pcr_ctrl_bank;
  logic i_core_clk, i_arst_n, i_mgmt_req, i_mgmt_we, o_mgmt_ack, i_sw_mode, i_an_started;
  logic [4:0] i_mgmt_addr, i_phy_addr;
  logic [15:0] i_mgmt_wdata, o_mgmt_rdata, rdat;
  logic [1:0] i_lh_event;
  logic [2:0] i_sm_state;
  logic [3:0] i_mac_txd, o_mac_rxd;
  logic i_ll_level, i_mac_tx_en, o_mac_rx_dv, o_mac_col, o_mac_oe, o_tp_tx_en, o_tp_rx_en;
  logic o_col_det_en, o_speed_100, o_full_duplex, o_an_enable, o_an_restart, o_low_power;
  logic o_sm_idle, ok;
  int err_count = 0;
  int checked = 0;
  int n;
  pcr_ctrl_bank u_pcr_ctrl_bank (.i_core_clk, .i_arst_n, .i_mgmt_req, .i_mgmt_we,
    .i_mgmt_addr, .i_mgmt_wdata, .o_mgmt_ack, .o_mgmt_rdata, .i_phy_addr, .i_sw_mode,
    .i_hw_speed_100(1'b1), .i_an_speed_100(1'b1), .i_an_started, .i_lh_event, .i_ll_level,
    .i_sm_state, .i_mac_txd, .i_mac_tx_en, .i_line_rxd(4'h0), .i_line_rx_dv(1'b0),
    .i_line_col(1'b0), .o_mac_rxd, .o_mac_rx_dv, .o_mac_col, .o_mac_oe, .o_tp_tx_en,
    .o_tp_rx_en, .o_col_det_en, .o_speed_100, .o_full_duplex, .o_an_enable, .o_an_restart,
    .o_low_power, .o_sm_idle);
  pcr_sta_model u_pcr_sta_model (.i_core_clk, .i_mgmt_ack(o_mgmt_ack),
    .i_mgmt_rdata(o_mgmt_rdata), .o_mgmt_req(i_mgmt_req), .o_mgmt_we(i_mgmt_we),
    .o_mgmt_addr(i_mgmt_addr), .o_mgmt_wdata(i_mgmt_wdata));
  initial begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk16
  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask : chk1
  task automatic acc(input logic we, input logic [4:0] a, input logic [15:0] d);
    u_pcr_sta_model.xfer(we, a, d, rdat, ok);
    if (!ok) begin
      err_count++;
      $display("mismatch at %0t: no answer", $time);
      tally_and_finish();
    end
  endtask : acc
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    acc(1'b0, a, 16'h0000);
    chk16(rdat, exp);
  endtask : rd
  task automatic step(input int k);
    repeat (k) @(posedge i_core_clk);
    #1;
  endtask : step
  initial begin
    {i_arst_n, i_phy_addr, i_lh_event, i_sm_state, i_mac_txd, i_mac_tx_en} = '0;
    {i_sw_mode, i_ll_level, i_an_started} = 3'b110;
    step(3);
    i_arst_n = 1'b1;
    step(2);
    rd(5'h00, 16'h3400);
    chk1(o_mac_oe, 1'b0);
    rd(5'h01, 16'h0001);
    rd(5'h07, 16'h0000);
    $display("test defaults done");
    {i_lh_event, i_ll_level, i_sm_state} = {2'b01, 1'b0, 3'h5};
    step(1);
    {i_lh_event, i_ll_level, i_sm_state} = {2'b00, 1'b1, 3'h2};
    step(1);
    rd(5'h01, 16'h002a);
    rd(5'h01, 16'h0011);
    $display("test latching done");
    acc(1'b1, 5'h00, 16'h40ff);
    rd(5'h00, 16'h4080);
    chk1(o_tp_tx_en, 1'b0);
    chk1(o_tp_rx_en, 1'b0);
    chk1(o_col_det_en, 1'b1);
    chk1(o_speed_100, 1'b0);
    chk1(o_mac_oe, 1'b1);
    {i_mac_txd, i_mac_tx_en} = {4'ha, 1'b1};
    step(1);
    chk1(o_mac_rx_dv, 1'b1);
    chk16({12'h000, o_mac_rxd}, 16'h000a);
    chk1(o_mac_col, 1'b1);
    i_mac_tx_en = 1'b0;
    $display("test loopback done");
    acc(1'b1, 5'h00, 16'h1200);
    chk1(o_an_restart, 1'b1);
    i_an_started = 1'b1;
    step(1);
    i_an_started = 1'b0;
    rd(5'h00, 16'h1000);
    acc(1'b1, 5'h00, 16'h0300);
    rd(5'h00, 16'h0100);
    chk1(o_full_duplex, 1'b1);
    $display("test restart done");
    {i_lh_event, i_ll_level} = 3'b100;
    step(1);
    {i_lh_event, i_ll_level} = 3'b001;
    acc(1'b1, 5'h00, 16'h0800);
    acc(1'b0, 5'h01, 16'h0000);
    chk16(rdat & 16'h0007, 16'h0001);
    $display("test low power done");
    acc(1'b1, 5'h00, 16'h8000);
    acc(1'b0, 5'h00, 16'h0000);
    chk1(rdat[15], 1'b1);
    chk1(o_sm_idle, 1'b1);
    rd(5'h01, 16'h0000);
    acc(1'b1, 5'h00, 16'h4000);
    n = 0;
    do begin
      acc(1'b0, 5'h00, 16'h0000);
      n++;
    end while (rdat[15] !== 1'b0 && n < 300);
    if (n >= 300) begin
      err_count++;
      $display("mismatch at %0t: reset never ended", $time);
      tally_and_finish();
    end
    chk16(rdat, 16'h3400);
    i_phy_addr = 5'h03;
    i_arst_n = 1'b0;
    step(3);
    i_arst_n = 1'b1;
    step(2);
    rd(5'h00, 16'h3000);
    chk1(o_mac_oe, 1'b1);
    $display("test resets done");
    tally_and_finish();
  end
endmodule : test_pcr_ctrl_bank
